// ### adcs_ctrl.v
// Control sequencer of a 10-bit successive-approximation converter with AHB-Lite registers
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "adcs_map.vh"

module adcs_ctrl #(
  parameter LARGE_VARIANT = 1,
  parameter INSTR_CLKS    = `ADCS_INSTR_CLKS
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire        special_event_i,
  input  wire        comparator_i,
  input  wire        rc_tick_i,
  output reg         timer_reset_o,
  output reg         analog_enable_o,
  output reg         hold_o,
  output reg  [9:0]  trial_code_o,
  output reg  [4:0]  channel_select_o,
  output reg         channel_connected_o,
  output reg  [1:0]  positive_ref_select_o,
  output reg         conversion_done_flag_o
);

  localparam S_IDLE   = 2'd0;
  localparam S_RCWAIT = 2'd1;
  localparam S_CONV   = 2'd2;

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [4:0] chan_reg;
  reg        go_reg;
  reg        en_reg;
  reg        just_reg;
  reg  [2:0] ccs_reg;
  reg  [1:0] pref_reg;
  reg  [7:0] resh_reg;
  reg  [7:0] resl_reg;
  reg        done_reg;
  reg  [9:0] sar_reg;
  reg  [9:0] sar_dec;
  reg  [3:0] nd_reg;
  reg  [4:0] hcnt_reg;
  reg  [3:0] wait_reg;
  reg        wr_pend_reg;
  reg  [7:0] wr_addr_reg;
  reg        rd_pend_reg;
  reg  [7:0] rd_addr_reg;
  reg  [7:0] rd_mux;
  reg  [9:0] load_val;
  reg  [7:0] fmt_h;
  reg  [7:0] fmt_l;
  wire       addr_ok;
  wire [7:0] wdata;
  wire       wr_ctrl;
  wire       wr_cfg;
  wire       wr_resh;
  wire       wr_resl;
  wire       wr_stat;
  wire       en_eff;
  wire       start;
  wire       stop_sw;
  wire       abort;
  wire       half_tick;
  wire       decide;
  wire       complete;
  wire       last_bit;
  wire [9:0] fill;
  wire       is_rc;

  // ****************************************************************
  // AHB-Lite slave front end
  // ****************************************************************
  assign addr_ok = hsel_i & htrans_i[1] & hready_i;
  assign wdata   = hwdata_i[7:0];
  assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `ADCS_OFS_CTRL);
  assign wr_cfg  = wr_pend_reg & (wr_addr_reg == `ADCS_OFS_CFG);
  assign wr_resh = wr_pend_reg & (wr_addr_reg == `ADCS_OFS_RESH);
  assign wr_resl = wr_pend_reg & (wr_addr_reg == `ADCS_OFS_RESL);
  assign wr_stat = wr_pend_reg & (wr_addr_reg == `ADCS_OFS_STAT);

  // Writes finish with zero wait, reads take one wait state
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite_i;
      wr_addr_reg <= haddr_i;
      hresp_o     <= 1'b0;
      if (addr_ok && !hwrite_i) begin
        rd_pend_reg <= 1'b1;
        rd_addr_reg <= haddr_i;
        hreadyout_o <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hreadyout_o <= 1'b1;
        hrdata_o    <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Read data; unimplemented bits and unmapped offsets read zero
  always @* begin
    case (rd_addr_reg)
      `ADCS_OFS_CTRL: rd_mux = {1'b0, chan_reg, go_reg, en_reg};
      `ADCS_OFS_CFG:  rd_mux = {just_reg, ccs_reg, 2'b00, pref_reg};
      `ADCS_OFS_RESH: rd_mux = resh_reg;
      `ADCS_OFS_RESL: rd_mux = resl_reg;
      `ADCS_OFS_STAT: rd_mux = {7'h00, done_reg};
      default:        rd_mux = 8'h00;
    endcase
  end

  // ****************************************************************
  // Start, stop and completion decisions
  // ****************************************************************
  assign en_eff   = wr_ctrl ? wdata[`ADCS_CTRL_EN_BIT] : en_reg;
  assign is_rc    = (ccs_reg[1:0] == `ADCS_CCS_RC_LOW);
  // One conversion for coincident starts; busy triggers dropped
  assign start    = (state_reg == S_IDLE) & en_eff &
                    ((wr_ctrl & wdata[`ADCS_CTRL_GO_BIT]) | special_event_i);
  assign stop_sw  = wr_ctrl & ~wdata[`ADCS_CTRL_GO_BIT];
  assign abort    = (state_reg != S_IDLE) & (stop_sw | ~en_eff);
  assign decide   = (state_reg == S_CONV) & half_tick & ~hcnt_reg[0] &
                    (hcnt_reg >= `ADCS_FIRST_DEC_HALF) &
                    (hcnt_reg <= `ADCS_LAST_DEC_HALF);
  // Last decision lands on the 23rd half bit period
  assign complete = decide & (hcnt_reg == `ADCS_LAST_DEC_HALF) & ~abort;

  adcs_tad_gen u_tad (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (state_reg == S_CONV),
    .clk_sel_i   (ccs_reg),
    .rc_tick_i   (rc_tick_i),
    .half_tick_o (half_tick)
  );

  // Sequencer state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:   if (start) state_next = is_rc ? S_RCWAIT : S_CONV;
      S_RCWAIT: if (abort) state_next = S_IDLE;
                else if (wait_reg == INSTR_CLKS - 1) state_next = S_CONV;
      S_CONV:   if (abort || complete) state_next = S_IDLE;
      default:  state_next = S_IDLE;
    endcase
  end

  // ****************************************************************
  // Successive approximation
  // ****************************************************************
  // Keep comparator result for the bit under test, try the next one
  always @* begin : sar_step
    integer k;
    sar_dec = sar_reg;
    for (k = 0; k < 10; k = k + 1) begin
      if (k == 9 - nd_reg) begin
        sar_dec[k] = comparator_i;
      end
      if (k == 8 - nd_reg) begin
        sar_dec[k] = 1'b1;
      end
    end
  end

  // Partial result: unconverted bits copy the last converted bit
  assign last_bit = (nd_reg == 4'd0) ? 1'b0 : sar_reg[4'd10 - nd_reg];
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_fill
      localparam [3:0] THR = 10 - gi;
      assign fill[gi] = (nd_reg >= THR) ? sar_reg[gi] : last_bit;
    end
  endgenerate

  // Result formatting by justify bit
  always @* begin
    load_val = complete ? sar_dec : fill;
    if (just_reg) begin
      fmt_h = {6'h00, load_val[9:8]};
      fmt_l = load_val[7:0];
    end else begin
      fmt_h = load_val[9:2];
      fmt_l = {load_val[1:0], 6'h00};
    end
  end

  // Sequencer registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      sar_reg   <= 10'h000;
      nd_reg    <= 4'd0;
      hcnt_reg  <= 5'd0;
      wait_reg  <= 4'd0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        sar_reg  <= 10'h200;
        nd_reg   <= 4'd0;
        hcnt_reg <= 5'd0;
        wait_reg <= 4'd0;
      end else begin
        if (state_reg == S_RCWAIT) begin
          wait_reg <= wait_reg + 4'd1;
        end
        if (state_reg == S_CONV && half_tick) begin
          hcnt_reg <= hcnt_reg + 5'd1;
        end
        if (decide) begin
          sar_reg <= sar_dec;
          nd_reg  <= nd_reg + 4'd1;
        end
      end
    end
  end

  // ****************************************************************
  // Software registers and flags
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_reg <= 5'h00;  // Channel field of the control reset value
      en_reg   <= 1'b0;
      go_reg   <= 1'b0;
      just_reg <= 1'b0;
      ccs_reg  <= 3'h0;
      pref_reg <= 2'h0;
      resh_reg <= `ADCS_RST_RES;
      resl_reg <= `ADCS_RST_RES;
      done_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        chan_reg <= wdata[`ADCS_CTRL_CHS_MSB:`ADCS_CTRL_CHS_LSB];
        en_reg   <= wdata[`ADCS_CTRL_EN_BIT];
      end
      if (wr_cfg) begin
        just_reg <= wdata[`ADCS_CFG_JUST_BIT];
        ccs_reg  <= wdata[`ADCS_CFG_CCS_MSB:`ADCS_CFG_CCS_LSB];
        pref_reg <= wdata[`ADCS_CFG_PREF_MSB:`ADCS_CFG_PREF_LSB];
      end
      // Go flag follows the sequencer, not the write data
      if (start) begin
        go_reg <= 1'b1;
      end else if (complete || abort) begin
        go_reg <= 1'b0;
      end
      // Hardware load wins over a software write
      if (complete || (abort && stop_sw && en_eff)) begin
        resh_reg <= fmt_h;
        resl_reg <= fmt_l;
      end else begin
        if (wr_resh) resh_reg <= wdata;
        if (wr_resl) resl_reg <= wdata;
      end
      // Done flag: set beats write-one-to-clear
      if (complete) begin
        done_reg <= 1'b1;
      end else if (wr_stat && wdata[`ADCS_STAT_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Analog side and trigger outputs
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reset_o          <= 1'b0;
      analog_enable_o        <= 1'b0;
      hold_o                 <= 1'b0;
      trial_code_o           <= 10'h000;
      channel_select_o       <= 5'h00;
      channel_connected_o    <= 1'b0;
      positive_ref_select_o  <= 2'h0;
      conversion_done_flag_o <= 1'b0;
    end else begin
      timer_reset_o          <= special_event_i;
      analog_enable_o        <= en_reg;
      hold_o                 <= (state_reg == S_CONV);
      trial_code_o           <= sar_reg;
      channel_select_o       <= chan_reg;
      // Pins, temperature, DAC and fixed reference only
      channel_connected_o    <= (chan_reg <= (LARGE_VARIANT ? `ADCS_CHS_PIN_LAST
                                                : `ADCS_CHS_PIN_SMALL)) |
                                (chan_reg >= `ADCS_CHS_TEMP);
      positive_ref_select_o  <= pref_reg;
      conversion_done_flag_o <= done_reg;
    end
  end

endmodule // adcs_ctrl

// ### adcs_ctrl_asserts.sv
// Port-level checks of the converter sequencer
`timescale 1ns/1ps
`include "adcs_map.vh"

module adcs_ctrl_chk #(
  parameter LARGE_VARIANT = 1
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        hsel_i,
  input wire [7:0]  haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        special_event_i,
  input wire        timer_reset_o,
  input wire        analog_enable_o,
  input wire        hold_o,
  input wire [4:0]  channel_select_o,
  input wire        channel_connected_o,
  input wire        conversion_done_flag_o
);
  // ********
  // Decode
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Accepted transfers and the expected channel connection
  wire       take = hsel_i && htrans_i[1] && hready_i;
  wire       rd   = take && !hwrite_i;
  wire [4:0] last = (LARGE_VARIANT != 0) ? `ADCS_CHS_PIN_LAST : `ADCS_CHS_PIN_SMALL;
  wire       conn = (channel_select_o <= last) || (channel_select_o >= `ADCS_CHS_TEMP);

  // ********
  // Assertions
  // ********
  AST_TRIG_TIMER: assert property (special_event_i |=> timer_reset_o)
    else $error("timer reset missing after trigger");
  AST_CTRL_TOP_ZERO: assert property ((rd && haddr_i == `ADCS_OFS_CTRL) |-> ##2 !hrdata_o[7])
    else $error("control bit 7 read nonzero");
  AST_CFG_GAP_ZERO: assert property ((rd && haddr_i == `ADCS_OFS_CFG) |-> ##2 hrdata_o[3:2] == 2'b00)
    else $error("config bits 3-2 read nonzero");
  AST_READ_WAIT: assert property (rd |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait cycle wrong");
  AST_WRITE_NOWAIT: assert property ((take && hwrite_i) |=> hreadyout_o)
    else $error("write stalled");
  AST_OKAY: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  AST_CHAN_MAP: assert property ((!$past(rst_i) && !$past(rst_i, 2)) |-> channel_connected_o == conn)
    else $error("channel connection wrong");
  AST_START_NEEDS_EN: assert property ($rose(hold_o) |-> analog_enable_o)
    else $error("conversion while disabled");
  AST_DONE_AT_END: assert property ($rose(conversion_done_flag_o) |-> $fell(hold_o))
    else $error("done flag apart from completion");

  // Main scenarios reached
  cover property ($rose(conversion_done_flag_o));
  cover property (special_event_i && hold_o);
  cover property ($fell(hold_o) && !conversion_done_flag_o);
endmodule // adcs_ctrl_chk

bind adcs_ctrl adcs_ctrl_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .special_event_i(special_event_i), .timer_reset_o(timer_reset_o),
  .analog_enable_o(analog_enable_o), .hold_o(hold_o), .channel_select_o(channel_select_o),
  .channel_connected_o(channel_connected_o), .conversion_done_flag_o(conversion_done_flag_o)
);

// ### adcs_ctrl_bench.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`include "adcs_map.vh"

module adcs_ctrl_bench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         hsel_i = 1'b0;
  reg  [7:0]  haddr_i = 8'h00;
  reg  [1:0]  htrans_i = 2'h0;
  reg         hwrite_i = 1'b0;
  reg  [31:0] hwdata_i = 32'h0;
  reg         special_event_i = 1'b0;
  wire        comparator_i;
  reg         rc_tick_i = 1'b0;
  reg  [1:0]  rcc = 2'h0;
  wire [31:0] hrdata_o;
  wire        hreadyout_o, hresp_o, timer_reset_o, analog_enable_o, hold_o;
  wire        channel_connected_o, conversion_done_flag_o;
  wire [9:0]  trial_code_o;
  wire [4:0]  channel_select_o;
  wire [1:0]  positive_ref_select_o;
  integer     seed = 32'h2c70, mismatches = 0, cmp_count = 0, n, i, p;
  reg  [9:0]  vin = 10'h0;
  reg  [15:0] want;
  reg  [31:0] rd;
  reg  [7:0]  cfg;
  reg  [4:0]  ch;
  reg         j;

  // Core clock, 100 ns
  always #50 clk_i = ~clk_i;
  // Ideal comparator answers the trial code at once, like the analog core
  assign comparator_i = (trial_code_o <= vin);
  // Slow RC tick, one pulse every four core clocks
  always @(posedge clk_i) begin
    rcc <= rcc + 2'h1;
    rc_tick_i <= (rcc == 2'h0);
  end

  adcs_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .special_event_i(special_event_i), .comparator_i(comparator_i), .rc_tick_i(rc_tick_i),
    .timer_reset_o(timer_reset_o), .analog_enable_o(analog_enable_o), .hold_o(hold_o),
    .trial_code_o(trial_code_o), .channel_select_o(channel_select_o),
    .channel_connected_o(channel_connected_o), .positive_ref_select_o(positive_ref_select_o),
    .conversion_done_flag_o(conversion_done_flag_o)
  );

  // ********
  // Tasks
  // ********
  // One AHB-Lite single word transfer
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e, input [8*8-1:0] nm);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  task pulse;
    begin
      @(posedge clk_i);
      special_event_i <= 1'b1;
      @(posedge clk_i);
      special_event_i <= 1'b0;
      @(posedge clk_i);
      chk("timer", 1, timer_reset_o);
    end
  endtask
  // Bounded wait for the done flag, cycles counted in n
  task wait_done;
    begin
      n = 0;
      while (conversion_done_flag_o !== 1'b1 && n < 3000) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n >= 3000) chk("timeout", 0, 1);
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Hang guard
  initial begin
    #3000000;
    mismatches = mismatches + 1;
    results;
  end

  // ********
  // Scenarios
  // ********
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`ADCS_OFS_CTRL, 32'h0, "ctrl");
    rdc(`ADCS_OFS_CFG, 32'h0, "cfg");
    rdc(8'h14, 32'h0, "unmapped");
    // Channel codes, reference codes and reserved bits
    for (i = 0; i < 12; i = i + 1) begin
      ch = (i < 4) ? 5'h1c + i : (i == 4) ? 5'h07 : (i == 5) ? 5'h08 : $random(seed);
      cfg = ($random(seed) & 8'hfc) | i[1:0];
      wr(`ADCS_OFS_CTRL, {1'b0, ch, 2'b01});
      wr(`ADCS_OFS_CFG, cfg);
      rdc(`ADCS_OFS_CTRL, {ch, 2'b01}, "ctrl");
      rdc(`ADCS_OFS_CFG, cfg & 8'hf3, "cfg");
      chk("chan", ch, channel_select_o);
      chk("conn", (ch < 8) || (ch > 28), channel_connected_o);
      chk("ref", cfg[1:0], positive_ref_select_o);
      chk("en", 1, analog_enable_o);
    end
    // Go with the converter off starts nothing
    wr(`ADCS_OFS_CTRL, 8'h02);
    repeat (3) @(posedge clk_i);
    chk("en", 0, analog_enable_o);
    chk("hold", 0, hold_o);
    // Every clock select, random level and format
    for (i = 0; i < 8; i = i + 1) begin
      vin = $random(seed);
      j = $random(seed);
      p = (i[1:0] == 2'h3) ? 4 : ((i[2] ? 2 : 1) << (2 * i[1:0]));
      wr(`ADCS_OFS_CFG, {j, i[2:0], 4'h0});
      wr(`ADCS_OFS_CTRL, 8'h01);
      wr(`ADCS_OFS_CTRL, 8'h03);
      wait_done;
      chk("n lo", 1, n >= ((i[1:0] == 2'h3) ? 4 + 23 * p : 23 * p - 3));
      chk("n hi", 1, n <= 23 * p + 8);
      rdc(`ADCS_OFS_STAT, 32'h1, "done");
      rdc(`ADCS_OFS_CTRL, 32'h1, "go");
      want = j ? {6'h0, vin} : {vin, 6'h0};
      rdc(`ADCS_OFS_RESH, want[15:8], "resh");
      rdc(`ADCS_OFS_RESL, want[7:0], "resl");
      wr(`ADCS_OFS_STAT, 8'h01);
      rdc(`ADCS_OFS_STAT, 32'h0, "done");
    end
    // Abort after four decisions at the slowest divider
    vin = $random(seed);
    wr(`ADCS_OFS_CFG, 8'he0);
    wr(`ADCS_OFS_CTRL, 8'h03);
    repeat (384) @(posedge clk_i);
    wr(`ADCS_OFS_CTRL, 8'h01);
    rdc(`ADCS_OFS_RESH, {6'h0, vin[9:8]}, "resh");
    rdc(`ADCS_OFS_RESL, {vin[7:6], {6{vin[6]}}}, "resl");
    rdc(`ADCS_OFS_STAT, 32'h0, "done");
    // Trigger start, then a trigger while busy
    wr(`ADCS_OFS_CFG, 8'h80);
    pulse;
    rdc(`ADCS_OFS_CTRL, 32'h3, "go");
    pulse;
    wait_done;
    repeat (4) @(posedge clk_i);
    chk("hold", 0, hold_o);
    rdc(`ADCS_OFS_CTRL, 32'h1, "go");
    wr(`ADCS_OFS_STAT, 8'h01);
    // Software start and trigger at the same edge
    fork
      wr(`ADCS_OFS_CTRL, 8'h03);
      begin
        @(posedge clk_i);
        pulse;
      end
    join
    wait_done;
    chk("done", 1, conversion_done_flag_o);
    repeat (4) @(posedge clk_i);
    chk("hold", 0, hold_o);
    rdc(`ADCS_OFS_CTRL, 32'h1, "go");
    results;
  end
endmodule // adcs_ctrl_bench

// ### adcs_map.vh
// Register map, field positions, reset values and timing counts of the converter sequencer
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADCS_OFS_CTRL      8'h00
`define ADCS_OFS_CFG       8'h04
`define ADCS_OFS_RESH      8'h08
`define ADCS_OFS_RESL      8'h0c
`define ADCS_OFS_STAT      8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCS_CTRL_EN_BIT   0
`define ADCS_CTRL_GO_BIT   1
`define ADCS_CTRL_CHS_LSB  2
`define ADCS_CTRL_CHS_MSB  6
`define ADCS_CFG_PREF_LSB  0
`define ADCS_CFG_PREF_MSB  1
`define ADCS_CFG_CCS_LSB   4
`define ADCS_CFG_CCS_MSB   6
`define ADCS_CFG_JUST_BIT  7
`define ADCS_STAT_DONE_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define ADCS_RST_CTRL      8'h00
`define ADCS_RST_CFG       8'h00
`define ADCS_RST_RES       8'h00

// ****************************************************************
// Channel codes
// ****************************************************************
`define ADCS_CHS_PIN_LAST  5'h07
`define ADCS_CHS_PIN_SMALL 5'h03
`define ADCS_CHS_TEMP      5'h1d
`define ADCS_CHS_DAC       5'h1e
`define ADCS_CHS_FIXREF    5'h1f

// ****************************************************************
// Conversion clock codes and half bit period lengths in core clocks
// ****************************************************************
`define ADCS_CCS_DIV2      3'h0
`define ADCS_CCS_DIV8      3'h1
`define ADCS_CCS_DIV32     3'h2
`define ADCS_CCS_DIV4      3'h4
`define ADCS_CCS_DIV16     3'h5
`define ADCS_CCS_DIV64     3'h6
`define ADCS_CCS_RC_LOW    2'h3
`define ADCS_HALF_DIV2     6'h01
`define ADCS_HALF_DIV4     6'h02
`define ADCS_HALF_DIV8     6'h04
`define ADCS_HALF_DIV16    6'h08
`define ADCS_HALF_DIV32    6'h10
`define ADCS_HALF_DIV64    6'h20

// ****************************************************************
// Conversion timing in half bit periods (11.5 bit periods); RC start wait in core clocks
// ****************************************************************
`define ADCS_CONV_HALF_TADS 5'd23
`define ADCS_FIRST_DEC_HALF 5'd4
`define ADCS_LAST_DEC_HALF  5'd22
`define ADCS_INSTR_CLKS     4

`endif

// ### adcs_tad_gen.v
// Half bit period tick generator for the conversion clock
`timescale 1ns/1ps
`include "adcs_map.vh"

module adcs_tad_gen (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       run_i,
  input  wire [2:0] clk_sel_i,
  input  wire       rc_tick_i,
  output reg        half_tick_o
);

  reg  [5:0] cnt_reg;
  reg  [5:0] half_len;
  wire       use_rc;

  // ****************************************************************
  // Divider selection
  // ****************************************************************
  assign use_rc = (clk_sel_i[1:0] == `ADCS_CCS_RC_LOW);

  // Half period length per clock code
  always @* begin
    case (clk_sel_i)
      `ADCS_CCS_DIV2:  half_len = `ADCS_HALF_DIV2;
      `ADCS_CCS_DIV8:  half_len = `ADCS_HALF_DIV8;
      `ADCS_CCS_DIV32: half_len = `ADCS_HALF_DIV32;
      `ADCS_CCS_DIV4:  half_len = `ADCS_HALF_DIV4;
      `ADCS_CCS_DIV16: half_len = `ADCS_HALF_DIV16;
      `ADCS_CCS_DIV64: half_len = `ADCS_HALF_DIV64;
      default:         half_len = `ADCS_HALF_DIV2;
    endcase
  end

  // Counter restarts whenever the sequencer is not converting
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg     <= 6'h00;
      half_tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg     <= 6'h00;
      half_tick_o <= 1'b0;
    end else if (use_rc) begin
      cnt_reg     <= 6'h00;
      half_tick_o <= rc_tick_i;  // RC source
    end else if (cnt_reg == half_len - 6'h01) begin
      cnt_reg     <= 6'h00;
      half_tick_o <= 1'b1;
    end else begin
      cnt_reg     <= cnt_reg + 6'h01;
      half_tick_o <= 1'b0;
    end
  end

endmodule // adcs_tad_gen
